//--- core/bmmu_top.sv
// Board memory map unit: address translation, device select, bus window, wait states
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) Thirty-two address maps live in PROM; software picks the active one.
// (RULE2) Every 64K processor address becomes a system address below 1M.
// (RULE3) Each map has 16 blocks of 4K, each with its own 4K-aligned base.
// (RULE4) A device map splits each block in 2K halves, one of seven devices each.
// (RULE5) Reset selects map zero, placing the first boot ROM socket at address zero.
// (RULE6) Only maps 0 to 7 are preset; the other 24 are user-defined.
// (RULE7) Bus masters reach DRAM through a strapped 16K/32K/64K size-aligned window.
// (RULE8) Processor can block bus access in 2K/4K/8K pieces matching window size.
// (RULE9) DRAM is dual-ported; processor accesses to it run at full speed.
// (RULE10) Zero to two wait states are inserted per device access.
// (RULE11) Wait counts set per DRAM, ROM, SRAM, NVRAM and per fetch or memory cycle. The DRAM table entries go unused; DRAM always gets zero waits.
// (RULE12) ROM sockets decode 128K total; static RAM in them is limited to 8K.
// (RULE13) The nonvolatile RAM device offers 256 bytes.
// (RULE14) Wait pattern comes from one of four strap-selected PROM tables.
// (RULE15) A five-bit map number written to map select picks the map; reset clears it.
module bmmu_top
    import bmmu_pkg::*;
#(
    parameter int NVRAM_BYTES = 256,
    parameter int SRAM_BYTES  = 8192
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Processor side
    input  wire logic        cpu_req_i,
    input  wire logic        cpu_fetch_i,
    input  wire logic [15:0] cpu_addr_i,
    output logic             cpu_ready_o,
    output logic      [19:0] sys_addr_o,
    output logic      [2:0]  dev_sel_o,
    output logic             dev_err_o,
    // System bus window onto DRAM
    input  wire logic [1:0]  win_size_strap_i,
    input  wire logic [23:0] win_base_strap_i,
    input  wire logic [1:0]  wait_table_strap_i,
    input  wire logic        bus_req_i,
    input  wire logic [23:0] bus_addr_i,
    output logic             bus_hit_o,
    output logic             bus_block_o,
    output logic      [15:0] bus_dram_addr_o
);
    // ****************************************************************
    // Storage: map PROM and wait tables
    // ****************************************************************
    // Map PROM, one 14-bit entry per map and block
    logic [13:0] map_prom [NUM_MAPS*NUM_BLOCKS];
    // Wait tables: table, class, fetch -> count
    logic [1:0]  wait_prom [NUM_TABLES*8];
    logic [4:0]  map_sel;
    logic [7:0]  protect;
    logic [8:0]  prom_addr;
    logic [4:0]  wait_addr;
    bmmu_state_t state;
    logic [1:0]  wait_cnt;

    // Default contents of a preset map entry
    function automatic logic [13:0] preset_entry(input logic [8:0] idx);
        logic [3:0] m;
        logic [3:0] b;
        m = {1'b0, idx[6:4]};
        b = idx[3:0];
        // Map 0 block 0 places boot ROM at system zero
        if (b == 4'h0)
            preset_entry = {BMMU_DEV_ROM0, BMMU_DEV_ROM0, 8'h00};     // see (RULE5)
        else if (b == 4'hF)
            preset_entry = {BMMU_DEV_NVRAM, BMMU_DEV_SRAM, 8'hFF};
        else
            preset_entry = {BMMU_DEV_DRAM, BMMU_DEV_DRAM, {m, b}};
    endfunction : preset_entry

    // Device code to wait class
    function automatic bmmu_cls_t dev_class(input logic [2:0] d);
        case (d)
            BMMU_DEV_DRAM:  dev_class = BMMU_CLS_DRAM;
            BMMU_DEV_SRAM:  dev_class = BMMU_CLS_SRAM;
            BMMU_DEV_NVRAM: dev_class = BMMU_CLS_NVRAM;
            default:        dev_class = BMMU_CLS_ROM;
        endcase
    endfunction : dev_class

    // ****************************************************************
    // APB register access
    // ****************************************************************
    logic apb_wr;
    logic apb_rd;
    assign apb_wr = psel_i && penable_i && pwrite_i && clk_en_i;
    assign apb_rd = psel_i && penable_i && !pwrite_i && clk_en_i;

    // Map select, protection and pointers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            map_sel   <= MAP_SEL_RESET;                                // see (RULE5) see (RULE15)
            protect   <= PROTECT_RESET;
            prom_addr <= 9'h000;
            wait_addr <= 5'h00;
        end else if (apb_wr && pready_o) begin                        // Lands at the completion edge
            case (paddr_i)
                REG_MAP_SEL:   map_sel   <= pwdata_i[4:0];             // see (RULE1) see (RULE15)
                REG_PROTECT:   protect   <= pwdata_i[7:0];             // see (RULE8)
                REG_PROM_ADDR: prom_addr <= pwdata_i[8:0];
                REG_WAIT_ADDR: wait_addr <= pwdata_i[4:0];
                default: ;
            endcase
        end
    end

    // PROM programming; only user maps are writable, presets are fixed
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_MAPS*NUM_BLOCKS; i++)
                map_prom[i] <= (i < NUM_PRESET*NUM_BLOCKS) ? preset_entry(9'(i)) : 14'h0000;
        end else if (apb_wr && pready_o && paddr_i == REG_PROM_DATA
                     && prom_addr[8:4] >= 5'(NUM_PRESET)) begin
            map_prom[prom_addr] <= pwdata_i[13:0];                      // see (RULE6)
        end
    end

    // Wait tables, reset to fixed patterns, writable for custom tables
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_TABLES*8; i++)
                wait_prom[i] <= (i[2:1] == 2'b00) ? 2'h0 : 2'((i >> 3) % (MAX_WAIT + 1));
        end else if (apb_wr && pready_o && paddr_i == REG_WAIT_DATA) begin
            // Values above two saturate so the limit always holds
            wait_prom[wait_addr] <= (pwdata_i[1:0] > 2'(MAX_WAIT)) ? 2'(MAX_WAIT) : pwdata_i[1:0]; // see (RULE10)
        end
    end

    // Single-wait-state APB answer
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else if (clk_en_i) begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= 1'b0;
            prdata_o  <= PSLVERR_DATA;
            if (apb_rd && !pready_o) begin
                case (paddr_i)
                    REG_MAP_SEL:   prdata_o <= {27'h0, map_sel};
                    REG_PROTECT:   prdata_o <= {24'h0, protect};
                    REG_WAIT_CFG:  prdata_o <= {30'h0, wait_table_strap_i};
                    REG_STATUS:    prdata_o <= {25'h0, dev_sel_o, win_size_strap_i, state};
                    REG_PROM_ADDR: prdata_o <= {23'h0, prom_addr};
                    REG_PROM_DATA: prdata_o <= {18'h0, map_prom[prom_addr]};
                    REG_WAIT_ADDR: prdata_o <= {27'h0, wait_addr};
                    REG_WAIT_DATA: prdata_o <= {30'h0, wait_prom[wait_addr]};
                    default:       pslverr_o <= 1'b1;
                endcase
            end else if (apb_wr && !pready_o) begin
                pslverr_o <= !(paddr_i inside {REG_MAP_SEL, REG_PROTECT, REG_PROM_ADDR,
                                               REG_PROM_DATA, REG_WAIT_ADDR, REG_WAIT_DATA});
            end
        end
    end

    // ****************************************************************
    // Processor translation and wait states
    // ****************************************************************
    logic [13:0] entry;
    logic [2:0]  dev;
    logic [1:0]  waits;
    logic        dev_bad;
    assign entry = map_prom[{map_sel, cpu_addr_i[15:12]}];                 // see (RULE1) see (RULE3)
    assign dev   = cpu_addr_i[11] ? entry[ENT_DHI_LSB +: 3] : entry[ENT_DLO_LSB +: 3]; // see (RULE4)
    // DRAM stays at full speed; the strapped table covers the rest
    assign waits = (dev == BMMU_DEV_DRAM) ? 2'h0                            // see (RULE9)
                 : wait_prom[{wait_table_strap_i, dev_class(dev), cpu_fetch_i}]; // see (RULE11) see (RULE14)
    // Offsets beyond small devices are refused rather than aliased
    assign dev_bad = (dev == BMMU_DEV_NVRAM && {5'h0, cpu_addr_i[10:0]} >= 16'(NVRAM_BYTES))  // see (RULE13)
                  || (dev == BMMU_DEV_SRAM && {5'h0, cpu_addr_i[10:0]} >= 16'(SRAM_BYTES)); // see (RULE12)

    // Access sequencer: count waits then give ready for one cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state       <= BMMU_IDLE;
            wait_cnt    <= 2'h0;
            cpu_ready_o <= 1'b0;
            sys_addr_o  <= 20'h00000;
            dev_sel_o   <= BMMU_DEV_NONE;
            dev_err_o   <= 1'b0;
        end else if (clk_en_i) begin
            cpu_ready_o <= 1'b0;
            case (state)
                BMMU_IDLE: begin
                    if (cpu_req_i) begin
                        sys_addr_o <= {entry[ENT_BASE_LSB +: 8], cpu_addr_i[11:0]}; // see (RULE2) see (RULE3)
                        dev_sel_o  <= dev;
                        dev_err_o  <= dev_bad;
                        wait_cnt   <= waits;                            // see (RULE10)
                        if (waits == 2'h0) begin
                            cpu_ready_o <= 1'b1;
                            state       <= BMMU_DONE;
                        end else begin
                            state <= BMMU_WAIT;
                        end
                    end
                end
                BMMU_WAIT: begin
                    if (wait_cnt == 2'h1) begin
                        cpu_ready_o <= 1'b1;
                        state       <= BMMU_DONE;
                    end
                    wait_cnt <= wait_cnt - 2'h1;
                end
                BMMU_DONE: begin
                    // Processor drops its request before the next access
                    if (!cpu_req_i) begin
                        state     <= BMMU_IDLE;
                        dev_sel_o <= BMMU_DEV_NONE;
                        dev_err_o <= 1'b0;
                    end
                end
                default: state <= BMMU_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // System bus window onto DRAM
    // ****************************************************************
    logic [23:0] win_mask;
    logic        hit;
    logic [15:0] off;
    logic [2:0]  blk;
    always_comb begin
        case (win_size_strap_i)
            BMMU_WIN_16K: win_mask = 24'hFFC000;
            BMMU_WIN_32K: win_mask = 24'hFF8000;
            default:      win_mask = 24'hFF0000;
        endcase
    end
    assign hit = ((bus_addr_i ^ win_base_strap_i) & win_mask) == 24'h000000; // see (RULE7)
    assign off = bus_addr_i[15:0] & ~win_mask[15:0];
    // One of eight protect bits per 2K, 4K or 8K piece of the window
    always_comb begin
        case (win_size_strap_i)
            BMMU_WIN_16K: blk = off[13:11];
            BMMU_WIN_32K: blk = off[14:12];
            default:      blk = off[15:13];
        endcase
    end

    // Registered window decode; the two ports never stall each other here
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_hit_o       <= 1'b0;
            bus_block_o     <= 1'b0;
            bus_dram_addr_o <= 16'h0000;
        end else if (clk_en_i) begin
            bus_hit_o       <= bus_req_i && hit && !protect[blk];      // see (RULE7) see (RULE9)
            bus_block_o     <= bus_req_i && hit && protect[blk];       // see (RULE8)
            bus_dram_addr_o <= off;
        end
    end
endmodule : bmmu_top
`default_nettype wire

//--- core/bmmu_pkg.sv
// Package of constants and types for the board memory map unit
package bmmu_pkg;
    // ****************************************************************
    // Register map (APB byte addresses)
    // ****************************************************************
    localparam logic [11:0] REG_MAP_SEL    = 12'h000;
    localparam logic [11:0] REG_PROTECT    = 12'h004;
    localparam logic [11:0] REG_WAIT_CFG   = 12'h008;
    localparam logic [11:0] REG_STATUS     = 12'h00C;
    localparam logic [11:0] REG_PROM_ADDR  = 12'h010;
    localparam logic [11:0] REG_PROM_DATA  = 12'h014;
    localparam logic [11:0] REG_WAIT_ADDR  = 12'h018;
    localparam logic [11:0] REG_WAIT_DATA  = 12'h01C;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int          NUM_MAPS       = 32;
    localparam int          NUM_PRESET     = 8;
    localparam int          NUM_BLOCKS     = 16;
    localparam int          NUM_TABLES     = 4;
    localparam int          MAX_WAIT       = 2;
    localparam logic [4:0]  MAP_SEL_RESET  = 5'h00;
    localparam logic [7:0]  PROTECT_RESET  = 8'h00;
    localparam logic [31:0] PSLVERR_DATA   = 32'h00000000;

    // Map entry field positions: base[7:0], dev_lo[10:8], dev_hi[13:11]
    localparam int          ENT_BASE_LSB   = 0;
    localparam int          ENT_DLO_LSB    = 8;
    localparam int          ENT_DHI_LSB    = 11;

    // On-board device codes chosen by the device map
    typedef enum logic [2:0] {
        BMMU_DEV_NONE  = 3'b000,
        BMMU_DEV_DRAM  = 3'b001,
        BMMU_DEV_ROM0  = 3'b010,
        BMMU_DEV_ROM1  = 3'b011,
        BMMU_DEV_ROM2  = 3'b100,
        BMMU_DEV_ROM3  = 3'b101,
        BMMU_DEV_SRAM  = 3'b110,
        BMMU_DEV_NVRAM = 3'b111
    } bmmu_dev_t;

    // Device class for wait-state lookup
    typedef enum logic [1:0] {
        BMMU_CLS_DRAM  = 2'b00,
        BMMU_CLS_ROM   = 2'b01,
        BMMU_CLS_SRAM  = 2'b10,
        BMMU_CLS_NVRAM = 2'b11
    } bmmu_cls_t;

    // Access sequencer states
    typedef enum logic [1:0] {
        BMMU_IDLE = 2'b00,
        BMMU_WAIT = 2'b01,
        BMMU_DONE = 2'b10
    } bmmu_state_t;

    // Window sizes by strap
    typedef enum logic [1:0] {
        BMMU_WIN_16K = 2'b00,
        BMMU_WIN_32K = 2'b01,
        BMMU_WIN_64K = 2'b10
    } bmmu_win_t;
endpackage : bmmu_pkg

//--- dv/bmmu_props.sv
// Concurrent checks on the board memory map unit ports
`timescale 1ns/1ps
`default_nettype none
module bmmu_props
    import bmmu_pkg::*;
#(
    parameter int NVRAM_BYTES = 256,
    parameter int SRAM_BYTES  = 8192
) (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        clk_en_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [31:0] prdata_o,
    input wire logic        cpu_req_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic        cpu_ready_o,
    input wire logic [19:0] sys_addr_o,
    input wire logic [2:0]  dev_sel_o,
    input wire logic        dev_err_o,
    input wire logic        bus_req_i,
    input wire logic        bus_hit_o,
    input wire logic        bus_block_o
);
    // ****************
    // Port relations
    // ****************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    a_apb_answer:
    assert property (psel_i && penable_i && clk_en_i && !pready_o |=> pready_o ##1 !pready_o)
        else $error("apb answer late or held");
    a_err_data:
    assert property (pready_o && pslverr_o |-> prdata_o == PSLVERR_DATA) else $error("error read data");
    a_cpu_bound:
    assert property ($rose(cpu_req_i) && clk_en_i |-> ##[1:3] cpu_ready_o) else $error("cpu answer late");
    a_dram_fast:
    assert property (cpu_ready_o && dev_sel_o == BMMU_DEV_DRAM |-> $past(cpu_req_i, 2) == 1'b0)
        else $error("dram access waited");
    a_sys_offset:
    assert property (cpu_ready_o |-> sys_addr_o[11:0] == cpu_addr_i[11:0]) else $error("offset lost");
    a_dev_release:
    assert property ($fell(cpu_req_i) && clk_en_i |=> dev_sel_o == 3'h0 && !dev_err_o)
        else $error("device select held");
    a_err_device:
    assert property (dev_err_o |-> dev_sel_o == BMMU_DEV_NVRAM || dev_sel_o == BMMU_DEV_SRAM)
        else $error("range error on wrong device");
    a_bus_idle:
    assert property (!bus_req_i && clk_en_i |=> !bus_hit_o && !bus_block_o) else $error("bus hit without request");
    a_bus_excl:
    assert property (!(bus_hit_o && bus_block_o)) else $error("hit and block together");
    // Main scenarios reached
    c_apb_err: cover property (pready_o && pslverr_o);
    c_cpu_wait2: cover property ($rose(cpu_req_i) ##3 cpu_ready_o);
    c_bus_block: cover property (bus_block_o);
endmodule : bmmu_props
bind bmmu_top bmmu_props #(.NVRAM_BYTES(NVRAM_BYTES), .SRAM_BYTES(SRAM_BYTES)) u_props (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .clk_en_i    (clk_en_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pready_o    (pready_o),
    .pslverr_o   (pslverr_o),
    .prdata_o    (prdata_o),
    .cpu_req_i   (cpu_req_i),
    .cpu_addr_i  (cpu_addr_i),
    .cpu_ready_o (cpu_ready_o),
    .sys_addr_o  (sys_addr_o),
    .dev_sel_o   (dev_sel_o),
    .dev_err_o   (dev_err_o),
    .bus_req_i   (bus_req_i),
    .bus_hit_o   (bus_hit_o),
    .bus_block_o (bus_block_o)
);
`default_nettype wire

//--- dv/bmmu_cpu_model.sv
// Processor-side model issuing memory cycles and timing the answer
`timescale 1ns/1ps
`default_nettype none
module bmmu_cpu_model (
    input  wire logic        core_clk_i,
    input  wire logic        cpu_ready_i,
    output logic             cpu_req_o,
    output logic             cpu_fetch_o,
    output logic      [15:0] cpu_addr_o
);
    // ****************
    // Memory cycle
    // ****************
    initial begin
        cpu_req_o   = 1'b0;
        cpu_fetch_o = 1'b0;
        cpu_addr_o  = 16'h0000;
    end
    // Request held until ready is sampled or lat reaches 8; lat counts edges to the answer
    task automatic access(input logic [15:0] addr, input logic fetch, output int lat);
        lat = 0;
        @(posedge core_clk_i);
        cpu_req_o   <= 1'b1;
        cpu_fetch_o <= fetch;
        cpu_addr_o  <= addr;
        do begin
            @(posedge core_clk_i);
            lat++;
        end while (cpu_ready_i !== 1'b1 && lat < 8);
        // Released lines show the inverse so no stale value can pass
        cpu_req_o   <= 1'b0;
        cpu_addr_o  <= ~addr;
        cpu_fetch_o <= ~fetch;
    endtask : access
endmodule : bmmu_cpu_model
`default_nettype wire

//--- dv/cpu_board_memory_map_unit_test.sv
// Self-checking testbench of the board memory map unit
`timescale 1ns/1ps
`default_nettype none
module cpu_board_memory_map_unit_test
    import bmmu_pkg::*;
;
    // ****************
    // Stimulus and checks
    // ****************
    logic        core_clk_i = 1'b0, rst_i = 1'b1, clk_en = 1'b1, e;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bus_req = 1'b0;
    logic        pready, pslverr, cpu_req, cpu_fetch, cpu_ready, dev_err, bus_hit, bus_block;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, r;
    logic [15:0] cpu_addr, bus_dram_addr;
    logic [19:0] sys_addr;
    logic [2:0]  dev_sel;
    logic [1:0]  win_size = 2'h0, wait_table = 2'h0;
    logic [23:0] win_base = 24'h100000, bus_addr = 24'h000000;
    int          n_mismatch = 0, total_checks = 0;
    bmmu_top DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cpu_req_i(cpu_req), .cpu_fetch_i(cpu_fetch), .cpu_addr_i(cpu_addr),
        .cpu_ready_o(cpu_ready), .sys_addr_o(sys_addr), .dev_sel_o(dev_sel), .dev_err_o(dev_err),
        .win_size_strap_i(win_size), .win_base_strap_i(win_base), .wait_table_strap_i(wait_table),
        .bus_req_i(bus_req), .bus_addr_i(bus_addr), .bus_hit_o(bus_hit), .bus_block_o(bus_block),
        .bus_dram_addr_o(bus_dram_addr));
    bmmu_cpu_model cpu (.core_clk_i(core_clk_i), .cpu_ready_i(cpu_ready), .cpu_req_o(cpu_req),
        .cpu_fetch_o(cpu_fetch), .cpu_addr_o(cpu_addr));
    always #12.5 core_clk_i = ~core_clk_i;
    task automatic check(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // One APB transfer; waits for the answer, never assumes its latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cyc(input logic [15:0] a, input logic f, input logic [19:0] sa, input logic [2:0] dv,
                       input logic er, input int lat);
        int l;
        cpu.access(a, f, l);
        #1;
        check(32'(sys_addr), 32'(sa), "system address");
        check(32'(dev_sel), 32'(dv), "device select");
        check(32'(dev_err), 32'(er), "range error");
        // Model counts from its launch edge, one edge before the taking edge
        check(32'(l - 1), 32'(lat), "answer latency");
    endtask : cyc
    task automatic bus(input logic [23:0] a, input logic hit, input logic blk);
        @(posedge core_clk_i);
        bus_req  <= 1'b1;
        bus_addr <= a;
        repeat (2) @(posedge core_clk_i);
        #1;
        check(32'(bus_hit), 32'(hit), "window hit");
        check(32'(bus_block), 32'(blk), "window block");
        if (hit) check(32'(bus_dram_addr), 32'(a[15:0]), "window offset");
        @(posedge core_clk_i);
        bus_req  <= 1'b0;
        bus_addr <= ~a;
    endtask : bus
    task automatic t_reset();
        apb(1'b0, REG_MAP_SEL, 32'h0);
        check(r, 32'(MAP_SEL_RESET), "map select reset");
        apb(1'b0, REG_PROTECT, 32'h0);
        check(r, 32'(PROTECT_RESET), "protect reset");
        cyc(16'h0000, 1'b1, 20'h00000, BMMU_DEV_ROM0, 1'b0, 1);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, e}, 32'h1, "unmapped error");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_maps();
        for (int m = 0; m < NUM_PRESET; m++) begin
            apb(1'b1, REG_MAP_SEL, 32'(m));
            cyc(16'h1234, 1'b0, {4'(m), 4'h1, 12'h234}, BMMU_DEV_DRAM, 1'b0, 1);
        end
        apb(1'b1, REG_MAP_SEL, 32'h00000025);
        apb(1'b0, REG_MAP_SEL, 32'h0);
        check(r, 32'h5, "five-bit map number");
        cyc(16'hF0FF, 1'b0, 20'hFF0FF, BMMU_DEV_SRAM, 1'b0, 1);
        cyc(16'hF900, 1'b0, 20'hFF900, BMMU_DEV_NVRAM, 1'b1, 1);
        $display("t_maps done");
    endtask : t_maps
    task automatic t_user();
        apb(1'b1, REG_PROM_ADDR, 32'h082);
        apb(1'b1, REG_PROM_DATA, 32'h39AB);
        apb(1'b1, REG_PROM_ADDR, 32'h032);
        apb(1'b1, REG_PROM_DATA, 32'h39AB);
        apb(1'b1, REG_MAP_SEL, 32'h8);
        cyc(16'h2345, 1'b0, 20'hAB345, BMMU_DEV_DRAM, 1'b0, 1);
        cyc(16'h28FF, 1'b0, 20'hAB8FF, BMMU_DEV_NVRAM, 1'b0, 1);
        apb(1'b1, REG_MAP_SEL, 32'h3);
        cyc(16'h2345, 1'b0, 20'h32345, BMMU_DEV_DRAM, 1'b0, 1);
        $display("t_user done");
    endtask : t_user
    task automatic t_wait();
        apb(1'b1, REG_MAP_SEL, 32'h0);
        apb(1'b1, REG_WAIT_ADDR, 32'h07);
        apb(1'b1, REG_WAIT_DATA, 32'h3);
        apb(1'b0, REG_WAIT_DATA, 32'h0);
        check(r, 32'h2, "wait saturation");
        apb(1'b1, REG_WAIT_ADDR, 32'h01);
        apb(1'b1, REG_WAIT_DATA, 32'h2);
        cyc(16'hF800, 1'b1, 20'hFF800, BMMU_DEV_NVRAM, 1'b0, 3);
        cyc(16'hF800, 1'b0, 20'hFF800, BMMU_DEV_NVRAM, 1'b0, 1);
        cyc(16'h1000, 1'b1, 20'h01000, BMMU_DEV_DRAM, 1'b0, 1);
        for (int t = 1; t < 3; t++) begin
            @(posedge core_clk_i);
            wait_table <= 2'(t);
            cyc(16'h0000, 1'b0, 20'h00000, BMMU_DEV_ROM0, 1'b0, t + 1);
        end
        $display("t_wait done");
    endtask : t_wait
    task automatic t_window();
        apb(1'b1, REG_PROTECT, 32'h02);
        for (int s = 0; s < 3; s++) begin
            win_size <= 2'(s);
            bus(24'h100004 + 24'(2048 << s), 1'b0, 1'b1);
            bus(24'h100004, 1'b1, 1'b0);
            bus(24'h100000 + 24'(16384 << s), 1'b0, 1'b0);
        end
        $display("t_window done");
    endtask : t_window
    // Mid-run reset: map zero again, strapped table 2 still gives ROM two waits
    task automatic t_rerun();
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, REG_MAP_SEL, 32'h0);
        check(r, 32'(MAP_SEL_RESET), "map select after reset");
        cyc(16'h0000, 1'b0, 20'h00000, BMMU_DEV_ROM0, 1'b0, 3);
        $display("t_rerun done");
    endtask : t_rerun
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    // Watchdog: the tests need about 220 cycles
    initial begin
        #100us;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_maps();
        t_user();
        t_wait();
        t_window();
        t_rerun();
        print_verdict();
    end
endmodule : cpu_board_memory_map_unit_test
`default_nettype wire
